// ===== inc/osdj_pkg.sv
// Package for the display attribute front end and vertical sync dejitter
package osdj_pkg;
  // Register indices on APB (printed offsets not all multiples of four, byte address is index x4)
  localparam logic [11:0] IDX_ADDR_LOW  = 12'hF97;
  localparam logic [11:0] IDX_ATTR      = 12'hF98;
  localparam logic [11:0] IDX_STATUS    = 12'hF9A;
  localparam logic [11:0] IDX_ADDR_HIGH = 12'hF96;
  localparam logic [11:0] IDX_DJ_CTRL   = 12'hF9B;
  localparam logic [11:0] IDX_CTRL      = 12'hF9C;
  localparam logic [11:0] IDX_IRQ_STAT  = 12'hF9D;
  localparam logic [11:0] IDX_IRQ_MASK  = 12'hF9E;
  localparam logic [13:0] ADDR_SHIFT    = 14'h0002;

  // Field positions
  localparam int DJ_EN_BIT     = 2;
  localparam int DJ_CKS_BIT    = 0;
  localparam int ST_DISP_BIT   = 0;
  localparam int ST_WIN_BIT    = 1;
  localparam int ST_BUSY_BIT   = 2;
  localparam int ST_OSC_BIT    = 4;
  localparam int CT_DISP_BIT   = 0;
  localparam int CT_WIN_BIT    = 1;
  localparam int CT_OSC_BIT    = 2;
  localparam int IRQ_COMMIT    = 0;
  localparam int IRQ_VLOCK     = 1;
  localparam int IRQ_VFREE     = 2;

  // Reset values
  localparam logic [7:0] ADDR_LOW_RST = 8'h00;
  localparam logic [7:0] ZERO8        = 8'h00;

  // Commit latency of a written datum into display memory, in cycles
  localparam logic [3:0] COMMIT_CYCLES = 4'h4;

  // Horizontal period counter width
  localparam int HCNT_W = 12;

  typedef struct packed {
    logic       reverse_blink_en;
    logic       reverse_en;
    logic       blink_en;
    logic [2:0] color;
  } osdj_attr_t;

  typedef struct packed {
    logic red;
    logic green;
    logic blue;
  } osdj_rgb_t;

  typedef enum logic [2:0] {
    C_BLACK   = 3'h0,
    C_BLUE    = 3'h1,
    C_GREEN   = 3'h2,
    C_CYAN    = 3'h3,
    C_RED     = 3'h4,
    C_MAGENTA = 3'h5,
    C_YELLOW  = 3'h6,
    C_WHITE   = 3'h7
  } osdj_color_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_XFER = 3'b010,
    ST_DONE = 3'b100
  } osdj_xfer_t;
endpackage

// ===== rtl/osdj_top.sv
// Attribute register front end and vertical sync jitter eliminator
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/100ps
module osdj_top
  import osdj_pkg::*;
#(
  parameter int HCNT_WIDTH = HCNT_W
) (
  // Clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 rst_in,
  // APB slave
  input  wire logic                 psel_in,
  input  wire logic                 penable_in,
  input  wire logic                 pwrite_in,
  input  wire logic [13:0]          paddr_in,
  input  wire logic [31:0]          pwdata_in,
  output logic      [31:0]          prdata_out,
  output logic                      pready_out,
  output logic                      pslverr_out,
  // Video sync inputs
  input  wire logic                 vertical_sync_n_in,
  input  wire logic                 horizontal_sync_n_in,
  // Display memory write port
  output logic      [8:0]           disp_addr_out,
  output osdj_pkg::osdj_attr_t      char_attribute_out,
  output osdj_pkg::osdj_rgb_t       char_rgb_out,
  output logic                      mem_write_out,
  // Internal vertical sync and interrupt
  output logic                      int_vertical_sync_n_out,
  output logic                      irq_out
);
  import osdj_pkg::*;

  logic [7:0]           disp_addr_low;
  logic                 disp_addr_bit8;
  osdj_attr_t           char_attribute;
  logic [7:0]           dejitter_control;
  logic [7:0]           disp_control;
  logic [7:0]           irq_status;
  logic [7:0]           irq_mask;
  osdj_xfer_t           xfer_state;
  logic [3:0]           xfer_cnt;
  logic                 vs_prev;
  logic                 hs_prev;
  logic [HCNT_WIDTH-1:0] hcnt;
  logic [HCNT_WIDTH-1:0] hperiod;
  logic                 pulse_pending;
  logic [HCNT_WIDTH-1:0] pulse_delay;
  logic                 vsync_pulse;
  logic [7:0]           display_status;
  logic [7:0]           next_irq_status;
  logic [7:0]           irq_events;
  logic                 wr_access;
  logic                 rd_access;
  logic [11:0]          reg_idx;
  logic                 known_idx;
  logic                 vs_fall;
  logic                 hs_fall;
  logic [HCNT_WIDTH-1:0] quarter;
  logic                 near_late;
  logic                 near_early;
  logic                 dejitter_enable;
  logic                 write_transfer_busy;

  // Single-cycle access phase; the slave never stalls
  assign pready_out  = 1'b1;
  assign reg_idx     = paddr_in[13:2];
  assign wr_access   = psel_in && penable_in && pwrite_in;
  assign rd_access   = psel_in && penable_in && !pwrite_in;
  assign known_idx   = (reg_idx == IDX_ADDR_LOW) || (reg_idx == IDX_ATTR) ||
                       (reg_idx == IDX_STATUS) || (reg_idx == IDX_ADDR_HIGH) ||
                       (reg_idx == IDX_DJ_CTRL) || (reg_idx == IDX_CTRL) ||
                       (reg_idx == IDX_IRQ_STAT) || (reg_idx == IDX_IRQ_MASK);
  assign pslverr_out = psel_in && penable_in && !known_idx;

  // Address registers; software writes low byte first, then bit eight
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      disp_addr_low  <= ADDR_LOW_RST;
      disp_addr_bit8 <= 1'b0;
    end else if (wr_access && reg_idx == IDX_ADDR_LOW) begin
      disp_addr_low <= pwdata_in[7:0];
    end else if (wr_access && reg_idx == IDX_ADDR_HIGH) begin
      disp_addr_bit8 <= pwdata_in[0];
    end
  end

  // Attribute byte; only six bits are implemented
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      char_attribute <= '0;
    end else if (wr_access && reg_idx == IDX_ATTR) begin
      char_attribute <= osdj_attr_t'(pwdata_in[5:0]);
    end
  end

  // Control registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      dejitter_control <= ZERO8;
      disp_control     <= ZERO8;
      irq_mask         <= ZERO8;
    end else if (wr_access) begin
      if (reg_idx == IDX_DJ_CTRL) begin
        dejitter_control <= pwdata_in[7:0];
      end
      if (reg_idx == IDX_CTRL) begin
        disp_control <= pwdata_in[7:0];
      end
      if (reg_idx == IDX_IRQ_MASK) begin
        irq_mask <= pwdata_in[7:0];
      end
    end
  end

  // Transfer of a written attribute into display memory
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      xfer_state <= ST_IDLE;
      xfer_cnt   <= 4'h0;
    end else begin
      case (xfer_state)
        ST_IDLE: begin
          if (wr_access && reg_idx == IDX_ATTR) begin
            xfer_state <= ST_XFER;
            xfer_cnt   <= COMMIT_CYCLES;
          end
        end
        ST_XFER: begin
          if (xfer_cnt == 4'h1) begin
            xfer_state <= ST_DONE;
          end
          xfer_cnt <= xfer_cnt - 4'h1;
        end
        ST_DONE: begin
          // A back-to-back attribute write restarts the transfer
          if (wr_access && reg_idx == IDX_ATTR) begin
            xfer_state <= ST_XFER;
            xfer_cnt   <= COMMIT_CYCLES;
          end else begin
            xfer_state <= ST_IDLE;
          end
        end
        default: begin
          xfer_state <= ST_IDLE;
        end
      endcase
    end
  end

  assign write_transfer_busy = (xfer_state != ST_IDLE);

  // Memory write outputs registered at commit
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      disp_addr_out      <= 9'h000;
      char_attribute_out <= '0;
      char_rgb_out       <= '0;
      mem_write_out      <= 1'b0;
    end else begin
      mem_write_out <= (xfer_state == ST_XFER) && (xfer_cnt == 4'h1);
      if ((xfer_state == ST_XFER) && (xfer_cnt == 4'h1)) begin
        disp_addr_out      <= {disp_addr_bit8, disp_addr_low};
        char_attribute_out <= char_attribute;
        char_rgb_out       <= osdj_rgb_t'(char_attribute.color);
      end
    end
  end

  // Status byte; oscillator mode is only a mirror of the control bit
  always_comb begin
    display_status              = ZERO8;
    display_status[ST_DISP_BIT] = disp_control[CT_DISP_BIT];
    display_status[ST_WIN_BIT]  = disp_control[CT_WIN_BIT];
    display_status[ST_BUSY_BIT] = write_transfer_busy;
    display_status[ST_OSC_BIT]  = disp_control[CT_OSC_BIT];
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (psel_in && !penable_in && !pwrite_in) begin
      case (reg_idx)
        IDX_STATUS:   prdata_out <= {24'h00_0000, display_status};
        IDX_DJ_CTRL:  prdata_out <= {24'h00_0000, dejitter_control};
        IDX_CTRL:     prdata_out <= {24'h00_0000, disp_control};
        IDX_IRQ_STAT: prdata_out <= {24'h00_0000, irq_status};
        IDX_IRQ_MASK: prdata_out <= {24'h00_0000, irq_mask};
        default:      prdata_out <= 32'h0000_0000;
      endcase
    end
  end

  // Edge detection on synchronous sync inputs
  assign vs_fall = vs_prev && !vertical_sync_n_in;
  assign hs_fall = hs_prev && !horizontal_sync_n_in;
  assign dejitter_enable = dejitter_control[DJ_EN_BIT];

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      vs_prev <= 1'b1;
      hs_prev <= 1'b1;
    end else begin
      vs_prev <= vertical_sync_n_in;
      hs_prev <= horizontal_sync_n_in;
    end
  end

  // Line period measurement between horizontal falling edges
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      hcnt    <= '0;
      hperiod <= '0;
    end else if (hs_fall) begin
      hperiod <= hcnt + 1'b1;
      hcnt    <= '0;
    end else if (hcnt != '1) begin
      hcnt <= hcnt + 1'b1;
    end
  end

  // Measured in CPU cycles, so the select bit only documents the clock rate
  assign quarter    = hperiod >> 2;
  assign near_late  = (hcnt < quarter);
  assign near_early = (hperiod > hcnt) && ((hperiod - hcnt) <= quarter);

  // Internal vsync: snapped to next line edge inside the near_early window, else passed through
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pulse_pending <= 1'b0;
      pulse_delay   <= '0;
      vsync_pulse   <= 1'b0;
    end else begin
      vsync_pulse <= 1'b0;
      if (vs_fall && dejitter_enable && hperiod != '0 && near_early) begin
        pulse_pending <= 1'b1;
        pulse_delay   <= hperiod - hcnt;
      end else if (vs_fall && dejitter_enable && hperiod != '0 && near_late) begin
        vsync_pulse <= 1'b1;
      end else if (vs_fall) begin
        vsync_pulse <= 1'b1;
      end else if (pulse_pending) begin
        if (pulse_delay <= 1 || hs_fall) begin
          pulse_pending <= 1'b0;
          vsync_pulse   <= 1'b1;
        end else begin
          pulse_delay <= pulse_delay - 1'b1;
        end
      end
    end
  end

  // Internal vsync held low while external vsync stays low
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      int_vertical_sync_n_out <= 1'b1;
    end else if (vsync_pulse) begin
      int_vertical_sync_n_out <= 1'b0;
    end else if (vertical_sync_n_in && !pulse_pending) begin
      int_vertical_sync_n_out <= 1'b1;
    end
  end

  // Sticky interrupt status; a new event wins over a clearing write
  always_comb begin
    irq_events              = ZERO8;
    irq_events[IRQ_COMMIT]  = mem_write_out;
    irq_events[IRQ_VLOCK]   = vsync_pulse && dejitter_enable;
    irq_events[IRQ_VFREE]   = vs_fall && !dejitter_enable;
    next_irq_status         = irq_status;
    if (wr_access && reg_idx == IDX_IRQ_STAT) begin
      next_irq_status = irq_status & ~pwdata_in[7:0];
    end
    next_irq_status = next_irq_status | irq_events;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_status <= ZERO8;
      irq_out    <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq_out    <= |(next_irq_status & irq_mask);
    end
  end
endmodule // osdj_top

// ===== bench/osdj_assertions.sv
// Checker for the attribute front end and vertical sync retiming
`timescale 1ns/100ps
module osdj_assertions
  import osdj_pkg::*;
(
  input wire logic                 clk_in,
  input wire logic                 rst_in,
  input wire logic                 psel_in,
  input wire logic                 penable_in,
  input wire logic                 pwrite_in,
  input wire logic [13:0]          paddr_in,
  input wire logic [31:0]          prdata_out,
  input wire logic                 vertical_sync_n_in,
  input wire osdj_pkg::osdj_attr_t char_attribute_out,
  input wire osdj_pkg::osdj_rgb_t  char_rgb_out,
  input wire logic                 mem_write_out,
  input wire logic                 int_vertical_sync_n_out,
  input wire logic                 irq_out
);
  logic [11:0] idx;
  logic        acc;
  assign idx = paddr_in[13:2];
  assign acc = psel_in && penable_in;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_attr_wr;
    acc && pwrite_in && idx == IDX_ATTR;
  endsequence
  sequence s_stat_rd;
    psel_in && !penable_in && !pwrite_in && idx == IDX_STATUS ##1 acc;
  endsequence
  commit_latency_a: assert property (s_attr_wr |-> ##[4:5] mem_write_out)
    else $error("commit pulse missing");
  commit_single_a: assert property (mem_write_out |=> !mem_write_out)
    else $error("commit pulse too long");
  busy_report_a: assert property (s_attr_wr ##[1:3] s_stat_rd |-> prdata_out[ST_BUSY_BIT])
    else $error("busy not reported");
  rgb_decode_a: assert property (mem_write_out |-> char_rgb_out == char_attribute_out.color)
    else $error("colour decode wrong");
  reset_state_a: assert property ($fell(rst_in) |-> !irq_out && int_vertical_sync_n_out)
    else $error("outputs not idle after reset");
  vs_release_a: assert property ($rose(vertical_sync_n_in) |-> ##[1:3] int_vertical_sync_n_out)
    else $error("internal vsync not released");
  vs_cause_a: assert property ($fell(int_vertical_sync_n_out) |-> !vertical_sync_n_in)
    else $error("internal vsync fell without cause");
  vs_idle_a: assert property (vertical_sync_n_in [*4] |-> int_vertical_sync_n_out)
    else $error("internal vsync low while external idle");
endmodule // osdj_assertions

bind osdj_top osdj_assertions u_chk (
  .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .prdata_out(prdata_out),
  .vertical_sync_n_in(vertical_sync_n_in), .char_attribute_out(char_attribute_out),
  .char_rgb_out(char_rgb_out), .mem_write_out(mem_write_out),
  .int_vertical_sync_n_out(int_vertical_sync_n_out), .irq_out(irq_out)
);

// ===== bench/osdj_sync_src.sv
// Free-running video sync source with a placeable vertical edge
`timescale 1ns/100ps
module osdj_sync_src #(
  parameter int HPER = 64,
  parameter int HLOW = 4
) (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Request, lead in cycles before a line start
  input  wire logic       go_in,
  input  wire logic [7:0] lead_in,
  // Syncs
  output logic            hs_n_out,
  output logic            vs_n_out
);
  logic [7:0] hcnt;
  logic [9:0] vcnt;
  logic       armed;
  // Line sync runs free, as a real source does
  assign hs_n_out = hcnt >= 8'(HLOW);
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      hcnt <= 8'h00;
      vcnt <= 10'h000;
      armed <= 1'b0;
      vs_n_out <= 1'b1;
    end else begin
      hcnt <= (hcnt == 8'(HPER - 1)) ? 8'h00 : hcnt + 8'h01;
      if (go_in) armed <= 1'b1;
      if (armed && hcnt == 8'(HPER - 1) - lead_in) begin
        vs_n_out <= 1'b0;
        armed <= 1'b0;
        vcnt <= 10'h001;
      end else if (vcnt != 10'h000) begin
        vcnt <= vcnt + 10'h001;
        // Three lines low, long enough for any retiming
        if (vcnt == 10'(3 * HPER)) begin
          vs_n_out <= 1'b1;
          vcnt <= 10'h000;
        end
      end
    end
  end
endmodule // osdj_sync_src

// ===== bench/osdj_top_test.sv
// Self-checking bench for the attribute front end and sync retiming
`timescale 1ns/100ps
module osdj_top_test;
  import osdj_pkg::*;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        psel_in = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in = 1'b0;
  logic [13:0] paddr_in = 14'h0000;
  logic [31:0] pwdata_in = 32'h0;
  logic [31:0] prdata_out, rd;
  logic        pready_out, pslverr_out, hs_n, vs_n, mem_write_out, int_vs_n, irq_out, err;
  logic        go = 1'b0;
  logic [7:0]  lead = 8'h00;
  logic [8:0]  disp_addr_out;
  osdj_attr_t  attr;
  osdj_rgb_t   rgb;
  int          miscompares = 0;
  int          total_checks = 0;
  always #25 clk_in = ~clk_in;
  osdj_top u_dut (
    .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .vertical_sync_n_in(vs_n), .horizontal_sync_n_in(hs_n), .disp_addr_out(disp_addr_out),
    .char_attribute_out(attr), .char_rgb_out(rgb), .mem_write_out(mem_write_out),
    .int_vertical_sync_n_out(int_vs_n), .irq_out(irq_out)
  );
  osdj_sync_src u_src (
    .clk_in(clk_in), .rst_in(rst_in), .go_in(go), .lead_in(lead),
    .hs_n_out(hs_n), .vs_n_out(vs_n)
  );
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic hang();
    miscompares++;
    give_verdict();
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic [11:0] idx, input logic wr, input logic [31:0] wd);
    int n;
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= {idx, 2'h0};
    pwdata_in <= wd;
    @(posedge clk_in);
    penable_in <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 16);
    if (pready_out !== 1'b1) hang();
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic wait_commit();
    int n;
    n = 0;
    while (mem_write_out !== 1'b1 && n < 16) begin
      @(negedge clk_in);
      n++;
    end
    if (mem_write_out !== 1'b1) hang();
  endtask
  task automatic irq_is(input string what, input logic exp);
    repeat (2) @(negedge clk_in);
    chk(what, {31'h0, exp}, {31'h0, irq_out});
  endtask
  task automatic t_regs();
    logic [5:0] v;
    logic [8:0] a;
    apb(IDX_STATUS, 1'b0, 32'h0);
    chk("status reset", 32'h0, rd & 32'h17);
    for (int c = 0; c < 8; c++) begin
      if (c == 0 || c == 4) begin
        a = (c == 0) ? 9'h1A5 : 9'h03C;
        apb(IDX_ADDR_LOW, 1'b1, {24'h0, a[7:0]});
        apb(IDX_ADDR_HIGH, 1'b1, {31'h0, a[8]});
      end
      v = {~c[2:0], c[2:0]};
      apb(IDX_ATTR, 1'b1, {26'h0, v});
      apb(IDX_STATUS, 1'b0, 32'h0);
      chk("busy", 32'h1, {31'h0, rd[ST_BUSY_BIT]});
      wait_commit();
      chk("addr", {23'h0, a}, {23'h0, disp_addr_out});
      chk("attr", {26'h0, v}, {26'h0, attr});
      chk("rgb", {29'h0, c[2:0]}, {29'h0, rgb});
      apb(IDX_STATUS, 1'b0, 32'h0);
      chk("idle", 32'h0, {31'h0, rd[ST_BUSY_BIT]});
    end
    for (int b = 0; b < 3; b++) begin
      apb(IDX_CTRL, 1'b1, 32'h1 << b);
      apb(IDX_STATUS, 1'b0, 32'h0);
      chk("status", (b == 2) ? 32'h10 : 32'h1 << b, rd & 32'h13);
    end
    apb(12'h010, 1'b0, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    chk("ready", 32'h1, {31'h0, pready_out});
    $display("test regs done");
  endtask
  task automatic t_irq();
    apb(IDX_IRQ_STAT, 1'b1, 32'h7);
    apb(IDX_IRQ_MASK, 1'b1, 32'h1);
    irq_is("irq clear", 1'b0);
    apb(IDX_ATTR, 1'b1, 32'h0);
    wait_commit();
    irq_is("irq set", 1'b1);
    apb(IDX_IRQ_MASK, 1'b1, 32'h0);
    irq_is("irq masked", 1'b0);
    apb(IDX_IRQ_MASK, 1'b1, 32'h1);
    irq_is("irq unmasked", 1'b1);
    apb(IDX_IRQ_STAT, 1'b1, 32'h1);
    irq_is("irq cleared", 1'b0);
    $display("test irq done");
  endtask
  task automatic vs_case(input logic [7:0] ld, input int lo, input int hi);
    int n;
    @(posedge clk_in);
    lead <= ld;
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    n = 0;
    while (vs_n !== 1'b0 && n < 200) begin
      @(negedge clk_in);
      n++;
    end
    n = 0;
    while (int_vs_n !== 1'b0 && n < 40) begin
      @(negedge clk_in);
      n++;
    end
    chk("vs delay", 32'h1, {31'h0, n >= lo && n <= hi});
    n = 0;
    while (int_vs_n !== 1'b1 && n < 400) begin
      @(negedge clk_in);
      n++;
    end
    if (int_vs_n !== 1'b1) hang();
  endtask
  task automatic t_sync();
    apb(IDX_DJ_CTRL, 1'b1, 32'h0);
    vs_case(8'h08, 1, 4);
    apb(IDX_DJ_CTRL, 1'b1, 32'h4);
    apb(IDX_DJ_CTRL, 1'b0, 32'h0);
    chk("dj ctrl", 32'h4, rd);
    vs_case(8'h08, 8, 12);
    vs_case(8'h20, 1, 4);
    apb(IDX_IRQ_STAT, 1'b0, 32'h0);
    chk("sync events", 32'h6, rd);
    $display("test sync done");
  endtask
  initial begin
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    t_regs();
    t_irq();
    t_sync();
    give_verdict();
  end
endmodule // osdj_top_test
